// >>> logic/dac_load_host.sv
// host-side controller that drives the double-buffered converter load pins
`timescale 1ns/1ps
module dac_load_host (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire logic                      ce,
	// configuration
	input  wire dac_load_pkg::load_mode_t  mode,
	// command port
	input  wire logic                      cmd_valid,
	output logic                           cmd_ready,
	input  wire dac_load_pkg::cmd_t        cmd,
	// converter pins
	output dac_load_pkg::dac_pins_t        pins
);
	import dac_load_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ALE, ST_HIBYTE, ST_LOW, ST_HOLD, ST_GAP, ST_UPD
	} state_t;

	state_t            state_reg, state_next;
	logic [CNT_W-1:0]  cnt_reg, cnt_next;
	cmd_t              cmd_reg, cmd_next;
	load_mode_t        mode_reg, mode_next;
	dac_pins_t         pins_reg, pins_next;
	logic              after_load_reg, after_load_next;

	assign cmd_ready = (state_reg == ST_IDLE);
	assign pins      = pins_reg;

	// ****************
	// sequencer
	// ****************
	// the counter counts whole cycles, so every least time is met or exceeded
	always_comb begin
		state_next      = state_reg;
		cnt_next        = cnt_reg;
		cmd_next        = cmd_reg;
		mode_next       = mode_reg;
		pins_next       = pins_reg;
		after_load_next = after_load_reg;
		case (state_reg)
			ST_IDLE: begin
				pins_next.addr_latch = 1'b0;
				if (cmd_valid) begin
					cmd_next  = cmd;
					mode_next = mode;
					// tied wiring leaves the update line resting high; the other schemes need it low
					// so the second rank holds while first ranks are loaded one by one
					if (mode != MODE_TIED) begin
						pins_next.output_update_strobe = 1'b0; // RQ10
					end
					if (cmd.kind == CMD_UPDATE) begin
						// keep the skew gap after a first rank load
						cnt_next   = after_load_reg ? 4'(SKEW_CYC) : CNT_ZERO;
						state_next = ST_GAP;
					end else if (mode == MODE_BYTE) begin
						pins_next.data[BYTE_W-1:0] = cmd.data[DATA_W-1:BYTE_W];
						pins_next.byte_latch_en_n  = 1'b0; // RQ12
						cnt_next                   = 4'(LOW_CYC);
						state_next                 = ST_HIBYTE;
					end else begin
						pins_next.data       = cmd.data;
						pins_next.addr_latch = 1'b1; // RQ8
						cnt_next             = 4'(ALE_CYC);
						state_next           = ST_ALE;
					end
				end
			end
			ST_HIBYTE: begin
				if (cnt_reg > CNT_ONE) begin
					cnt_next = cnt_reg - CNT_ONE;
				end else begin
					// upper byte now held by the external latch; put the lower byte on the bus
					pins_next.byte_latch_en_n  = 1'b1; // RQ12
					pins_next.data             = cmd_reg.data;
					pins_next.decoded_select_n[cmd_reg.dac_sel] = 1'b0; // RQ13
					pins_next.first_rank_load_n = 1'b0; // RQ13
					cnt_next                    = 4'(LOW_CYC);
					state_next                  = ST_LOW;
				end
			end
			ST_ALE: begin
				if (cnt_reg > CNT_ONE) begin
					cnt_next = cnt_reg - CNT_ONE;
				end else begin
					// address is captured before select falls
					pins_next.addr_latch = 1'b0; // RQ8
					pins_next.decoded_select_n[cmd_reg.dac_sel] = 1'b0;
					// the first rank only opens with load low, so tied wiring drives it too
					pins_next.first_rank_load_n = 1'b0; // RQ9
					if (mode_reg == MODE_TIED) begin
						// tied wiring: update follows the same select line
						pins_next.output_update_strobe = 1'b0; // RQ4
					end
					cnt_next   = 4'(LOW_CYC); // RQ6 RQ7
					state_next = ST_LOW;
				end
			end
			ST_LOW: begin
				if (cnt_reg > CNT_ONE) begin
					cnt_next = cnt_reg - CNT_ONE;
				end else begin
					// write strobe and select rise in the same cycle; data is held after that
					pins_next.first_rank_load_n = 1'b1; // RQ9
					pins_next.decoded_select_n  = '1; // RQ5
					if (mode_reg == MODE_TIED) begin
						pins_next.output_update_strobe = 1'b1; // RQ5
					end
					after_load_next = (mode_reg != MODE_TIED);
					cnt_next        = 4'(HOLD_CYC);
					state_next      = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// data stays on the bus past the closing edge
				if (cnt_reg > CNT_ONE) begin
					cnt_next = cnt_reg - CNT_ONE; // RQ14
				end else begin
					cnt_next   = 4'(HIGH_CYC);
					state_next = ST_GAP;
				end
			end
			ST_GAP: begin
				if (cnt_reg > CNT_ONE) begin
					cnt_next = cnt_reg - CNT_ONE;
				end else if (cmd_reg.kind == CMD_UPDATE && !pins_reg.output_update_strobe) begin
					// one shared positive pulse refreshes every converter
					pins_next.output_update_strobe = 1'b1; // RQ10 RQ3
					after_load_next                = 1'b0;
					cnt_next                       = 4'(LOW_CYC);
					state_next                     = ST_UPD;
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_UPD: begin
				if (cnt_reg > CNT_ONE) begin
					cnt_next = cnt_reg - CNT_ONE;
				end else begin
					pins_next.output_update_strobe = 1'b0; // RQ11
					cmd_next.kind                  = CMD_WRITE;
					cnt_next                       = 4'(HIGH_CYC);
					state_next                     = ST_GAP;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// state registers, frozen while ce is low
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg      <= ST_IDLE;
			cnt_reg        <= CNT_ZERO;
			cmd_reg        <= '0;
			mode_reg       <= MODE_TIED;
			after_load_reg <= 1'b0;
			pins_reg       <= '{decoded_select_n: '1, first_rank_load_n: 1'b1,
				output_update_strobe: 1'b0, addr_latch: 1'b0, byte_latch_en_n: 1'b1, data: '0};
		end else if (ce) begin
			state_reg      <= state_next;
			cnt_reg        <= cnt_next;
			cmd_reg        <= cmd_next;
			mode_reg       <= mode_next;
			after_load_reg <= after_load_next;
			pins_reg       <= pins_next;
		end
	end

	// ****************
	// assertions
	// ****************
	// length of the current low phase of the load line, saturating so it never wraps
	logic [CNT_W-1:0] low_run_reg, low_run_next;

	always_comb begin
		low_run_next = low_run_reg;
		if (pins_reg.first_rank_load_n) begin
			low_run_next = CNT_ZERO;
		end else if (low_run_reg != '1) begin
			low_run_next = low_run_reg + CNT_ONE;
		end
	end

	// counts enabled cycles only, since the pins are frozen with the state
	always_ff @(posedge clk) begin
		if (!rstn) begin
			low_run_reg <= CNT_ZERO;
		end else if (ce) begin
			low_run_reg <= low_run_next;
		end
	end

	property p_low_time;
		@(posedge clk) disable iff (!rstn)
		$rose(pins.first_rank_load_n) |-> (low_run_reg >= 4'(LOW_CYC));
	endproperty
	a_low_time: assert property (p_low_time) else $error("load low too short"); // RQ6
	property p_sel_after_ale;
		@(posedge clk) disable iff (!rstn)
		($fell(pins.decoded_select_n[0]) && mode_reg != MODE_BYTE) |-> $past(pins.addr_latch);
	endproperty
	a_sel_after_ale: assert property (p_sel_after_ale) else $error("select before address latch"); // RQ8
	property p_hold;
		@(posedge clk) disable iff (!rstn)
		($rose(pins.first_rank_load_n) && ce) |=> $stable(pins.data);
	endproperty
	a_hold: assert property (p_hold) else $error("data changed at closing edge"); // RQ14
	property p_tied;
		@(posedge clk) disable iff (!rstn)
		(mode_reg == MODE_TIED && state_reg == ST_LOW) |->
			(!pins.output_update_strobe && !pins.first_rank_load_n &&
			pins.decoded_select_n[cmd_reg.dac_sel] == 1'b0);
	endproperty
	a_tied: assert property (p_tied) else $error("tied mode lines differ"); // RQ4
	property p_upd_pulse;
		@(posedge clk) disable iff (!rstn)
		($rose(pins.output_update_strobe) && state_reg == ST_UPD) |-> pins.decoded_select_n == '1;
	endproperty
	a_upd_pulse: assert property (p_upd_pulse) else $error("update with select low"); // RQ10
	property p_byte_order;
		@(posedge clk) disable iff (!rstn)
		($fell(pins.first_rank_load_n) && mode_reg == MODE_BYTE) |-> !$past(pins.byte_latch_en_n);
	endproperty
	a_byte_order: assert property (p_byte_order) else $error("lower byte before upper"); // RQ12
	property p_together;
		@(posedge clk) disable iff (!rstn)
		($fell(pins.first_rank_load_n) && mode_reg != MODE_TIED) |-> pins.decoded_select_n != '1;
	endproperty
	a_together: assert property (p_together) else $error("load without select"); // RQ13
	property p_upd_end;
		@(posedge clk) disable iff (!rstn)
		(state_reg == ST_UPD && ce) |-> ##[1:4] !pins.output_update_strobe;
	endproperty
	a_upd_end: assert property (p_upd_end) else $error("update pulse not ended"); // RQ11
	c_tied: cover property (@(posedge clk) mode_reg == MODE_TIED && $rose(pins.output_update_strobe));
	c_update: cover property (@(posedge clk) state_reg == ST_UPD);
	c_byte: cover property (@(posedge clk) mode_reg == MODE_BYTE && $fell(pins.first_rank_load_n));
endmodule

// >>> logic/dac_load_pkg.sv
// package with constants, types and the functional notes for the converter load controller
// Functional notes
// RQ1: first rank transparent while select and load low
// RQ2: second rank follows first while update high
// RQ3: update strobe ignores select and other controls
// RQ4: all controls tied give edge-triggered register
// RQ5: select rising edge captures and updates together
// RQ6: host stretches select low for minimum time
// RQ7: wait-state count rounds up, never down
// RQ8: address latched before select driven low; byte mode drives select low with no address latch pulse
// RQ9: write strobe rising edge captures data word
// RQ10: one update write pulses shared update strobe
// RQ11: update falling edge holds value until next
// RQ12: upper byte latched first, then lower byte
// RQ13: select and load low together after bytes
// RQ14: data held stable past closing strobe edge
package dac_load_pkg;
	// ****************
	// timing constants
	// ****************
	localparam int CLK_PERIOD_NS   = 40;
	localparam int T_LOW_NS        = 40;   // least low time of select and load
	localparam int T_HIGH_NS       = 40;   // least high time between writes
	localparam int T_SKEW_NS       = 100;  // gap from first rank load to update
	localparam int T_HOLD_NS       = 40;   // data kept after closing edge
	localparam int T_ALE_NS        = 40;   // address latch pulse width
	// least times round up to whole cycles, none below one
	localparam int LOW_CYC  = ((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int HIGH_CYC = ((T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int SKEW_CYC = ((T_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int HOLD_CYC = ((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int ALE_CYC  = ((T_ALE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_ALE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int CNT_W    = 4;
	localparam int DATA_W   = 16;
	localparam int BYTE_W   = 8;
	localparam int NUM_DAC  = 4;

	// ****************
	// types
	// ****************
	typedef enum logic [1:0] {
		MODE_TIED,   // select, load and update tied to one line
		MODE_MULTI,  // per-converter loads then one shared update
		MODE_BYTE    // two bytes through an external octal latch
	} load_mode_t;

	typedef enum logic [1:0] {
		CMD_WRITE,   // write a word (tied, multi or byte mode)
		CMD_UPDATE   // pulse shared update strobe
	} cmd_kind_t;

	typedef struct packed {
		cmd_kind_t         kind;
		logic [1:0]        dac_sel;
		logic [DATA_W-1:0] data;
	} cmd_t;

	typedef struct packed {
		logic [NUM_DAC-1:0] decoded_select_n;
		logic               first_rank_load_n;
		logic               output_update_strobe;
		logic               addr_latch;
		logic               byte_latch_en_n;
		logic [DATA_W-1:0]  data;
	} dac_pins_t;

	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
endpackage

// >>> verification/dac_rank_model.sv
// behavioural model of the double-buffered converters and the byte latch
`timescale 1ns/1ps
module dac_rank_model (
	// pins from the host controller
	input  wire dac_load_pkg::dac_pins_t  pins,
	input  wire dac_load_pkg::load_mode_t mode,
	// latch contents seen by the bench
	output logic [dac_load_pkg::DATA_W-1:0] rank1 [dac_load_pkg::NUM_DAC],
	output logic [dac_load_pkg::DATA_W-1:0] rank2 [dac_load_pkg::NUM_DAC]
);
	import dac_load_pkg::*;
	logic [BYTE_W-1:0] octal;
	logic [DATA_W-1:0] word;

	// ****************
	// byte path
	// ****************
	// octal latch follows the low byte while enabled, holds it after
	always_latch if (!pins.byte_latch_en_n) octal <= pins.data[BYTE_W-1:0];
	// only byte mode takes the upper half from the octal latch
	assign word = (mode == MODE_BYTE) ? {octal, pins.data[BYTE_W-1:0]} : pins.data;

	// ****************
	// two ranks
	// ****************
	// level latches; the update line is not gated by any select, so tied controls act as an edge register
	for (genvar k = 0; k < NUM_DAC; k++) begin : g_dac
		always_latch if (!pins.decoded_select_n[k] && !pins.first_rank_load_n) rank1[k] <= word;
		always_latch if (pins.output_update_strobe) rank2[k] <= rank1[k];
	end
endmodule

// >>> verification/dual_rank_dac_load_port_bench.sv
// self-checking bench for the converter load controller
`timescale 1ns/1ps
module dual_rank_dac_load_port_bench;
	import dac_load_pkg::*;
	localparam int LIMIT = 3000;
	logic              clk, rstn, ce, cmd_valid, cmd_ready;
	load_mode_t        mode;
	cmd_t              cmd;
	dac_pins_t         pins;
	logic [DATA_W-1:0] rank1 [NUM_DAC];
	logic [DATA_W-1:0] rank2 [NUM_DAC];
	logic [DATA_W-1:0] vals  [NUM_DAC];
	int                fails, compares, cycles;

	dac_load_host dut (.clk(clk), .rstn(rstn), .ce(ce), .mode(mode), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .pins(pins));
	dac_rank_model far (.pins(pins), .mode(mode), .rank1(rank1), .rank2(rank2));

	// ****************
	// clock and watchdog
	// ****************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// a hang counts as a mismatch and ends the run
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			report_and_stop();
		end
	end

	// ****************
	// shared tasks
	// ****************
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// hold the request until the edge that takes it, then wait for idle
	task automatic send(input load_mode_t m, input cmd_kind_t k, input logic [1:0] s, input logic [15:0] d);
		int n;
		mode = m;
		cmd = '{kind: k, dac_sel: s, data: d};
		cmd_valid = 1'b1;
		for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(posedge clk) #1;
		@(posedge clk) #1;
		cmd_valid = 1'b0;
		for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(posedge clk) #1;
	endtask
	task automatic do_reset;
		rstn = 1'b0;
		repeat (4) @(posedge clk);
		#1 rstn = 1'b1;
		chk(pins, {4'hF, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0000});
		chk({23'h000000, cmd_ready}, 24'h000001);
	endtask

	// ****************
	// scenarios
	// ****************
	// two rounds of separate loads; second rank must wait for the shared pulse
	task automatic test_multi;
		logic [15:0] m;
		for (int r = 0; r < 2; r++) begin
			m = r ? 16'hFFFF : 16'h0000;
			for (int k = 0; k < NUM_DAC; k++) send(MODE_MULTI, CMD_WRITE, 2'(k), vals[k] ^ m);
			for (int k = 0; k < NUM_DAC; k++) chk(rank1[k], vals[k] ^ m);
			if (r) for (int k = 0; k < NUM_DAC; k++) chk(rank2[k], vals[k]);
			send(MODE_MULTI, CMD_UPDATE, 2'h0, 16'h0000);
			for (int k = 0; k < NUM_DAC; k++) chk(rank2[k], vals[k] ^ m);
		end
	endtask
	// one tied write must reach the output at once
	task automatic test_tied;
		for (int k = 0; k < NUM_DAC; k++) begin
			send(MODE_TIED, CMD_WRITE, 2'(k), vals[k] ^ 16'h5A5A);
			chk(rank2[k], vals[k] ^ 16'h5A5A);
		end
	endtask
	task automatic test_byte;
		for (int k = 0; k < NUM_DAC; k++) begin
			send(MODE_BYTE, CMD_WRITE, 2'(k), vals[k] ^ 16'h3C3C);
			chk(rank1[k], vals[k] ^ 16'h3C3C);
			chk(rank2[k], vals[k] ^ 16'h5A5A);
		end
	endtask

	task automatic report_and_stop;
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		cmd_valid = 1'b0;
		mode = MODE_MULTI;
		cmd = '0;
		fails = 0;
		compares = 0;
		cycles = 0;
		vals = '{16'hFFFF, 16'h0000, 16'h8000, 16'h7FFF};
		do_reset();
		test_multi();
		test_tied();
		test_byte();
		do_reset();
		report_and_stop();
	end
endmodule
